//--- include/acat_pkg.sv
package acat_pkg;

    // ------------------------------------------------------------------
    // Register indexes, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_RATIO_OVER = 8'h3a;
    localparam logic [7:0] IDX_RATIO_UNDER = 8'h3b;
    localparam logic [7:0] IDX_ABS_OVER = 8'h3c;
    localparam logic [7:0] IDX_ABS_UNDER = 8'h3d;
    localparam logic [7:0] IDX_REF_SELECT = 8'h48;
    localparam logic [7:0] IDX_ALERT_STATUS = 8'h49;
    localparam int ADDR_LSB = 2;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int LIMIT_W = 12;
    localparam int LIMIT_LSB = 4;
    localparam int LIMIT_MSB = 15;
    localparam logic [11:0] OVER_RESET = 12'hfff;
    localparam logic [11:0] UNDER_RESET = 12'h000;
    localparam int ALERT_OVER_BIT = 0;
    localparam int ALERT_UNDER_BIT = 1;

    typedef enum logic [2:0] {
        ACAT_SEL_NONE,
        ACAT_SEL_RATIO_OVER,
        ACAT_SEL_RATIO_UNDER,
        ACAT_SEL_ABS_OVER,
        ACAT_SEL_ABS_UNDER,
        ACAT_SEL_REF_SELECT,
        ACAT_SEL_ALERT_STATUS
    } acat_sel_e;

endpackage

//--- core/acat_thresholds.sv
`timescale 1ns/100ps
module acat_thresholds #(
    parameter int NUM_CH = 6,
    parameter int CH_W = 3,
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scan_valid,
    input wire logic [CH_W-1:0] scan_channel,
    input wire logic [11:0] scan_result,
    output logic aux_over_alert,
    output logic aux_under_alert
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic acat_pkg::acat_sel_e decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] idx;
        idx = a[ADDR_W-1:acat_pkg::ADDR_LSB];
        if (a[1:0] != 2'h0) begin
            return acat_pkg::ACAT_SEL_NONE;
        end
        case (idx)
            (ADDR_W-2)'(acat_pkg::IDX_RATIO_OVER): return acat_pkg::ACAT_SEL_RATIO_OVER;
            (ADDR_W-2)'(acat_pkg::IDX_RATIO_UNDER): return acat_pkg::ACAT_SEL_RATIO_UNDER;
            (ADDR_W-2)'(acat_pkg::IDX_ABS_OVER): return acat_pkg::ACAT_SEL_ABS_OVER;
            (ADDR_W-2)'(acat_pkg::IDX_ABS_UNDER): return acat_pkg::ACAT_SEL_ABS_UNDER;
            (ADDR_W-2)'(acat_pkg::IDX_REF_SELECT): return acat_pkg::ACAT_SEL_REF_SELECT;
            (ADDR_W-2)'(acat_pkg::IDX_ALERT_STATUS): return acat_pkg::ACAT_SEL_ALERT_STATUS;
            default: return acat_pkg::ACAT_SEL_NONE;
        endcase
    endfunction

    function automatic logic [31:0] limit_word(input logic [11:0] lim);
        return {16'h0000, lim, 4'h0};
    endfunction

    acat_pkg::acat_sel_e sel;
    logic wr_en;
    logic setup;
    logic [11:0] ratio_over_q;
    logic [11:0] ratio_under_q;
    logic [11:0] abs_over_q;
    logic [11:0] abs_under_q;
    logic [NUM_CH-1:0] ref_select_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic [11:0] wr_limit;
    logic lo_strobes;
    logic [NUM_CH-1:0] wr_ref;

    assign sel = decode(paddr);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign wr_limit = pwdata[acat_pkg::LIMIT_MSB:acat_pkg::LIMIT_LSB];
    assign lo_strobes = pstrb[1] && pstrb[0];
    assign wr_ref = pwdata[NUM_CH-1:0];

    // Zero wait states; error only shown in the access phase
    assign pready = 1'b1;
    assign pslverr = penable && err_q;
    assign prdata = rdata_q;

    // ------------------------------------------------------------------
    // Limit registers
    // ------------------------------------------------------------------
    // A limit straddles both low byte lanes, so it moves only as a whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_over_q <= acat_pkg::OVER_RESET;
            ratio_under_q <= acat_pkg::UNDER_RESET;
            abs_over_q <= acat_pkg::OVER_RESET;
            abs_under_q <= acat_pkg::UNDER_RESET;
        end else if (wr_en && lo_strobes) begin
            case (sel)
                acat_pkg::ACAT_SEL_RATIO_OVER: ratio_over_q <= wr_limit;
                acat_pkg::ACAT_SEL_RATIO_UNDER: ratio_under_q <= wr_limit;
                acat_pkg::ACAT_SEL_ABS_OVER: abs_over_q <= wr_limit;
                acat_pkg::ACAT_SEL_ABS_UNDER: abs_under_q <= wr_limit;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_select_q <= '0;
        end else if (wr_en && pstrb[0] && sel == acat_pkg::ACAT_SEL_REF_SELECT) begin
            ref_select_q <= wr_ref;
        end
    end

    // ------------------------------------------------------------------
    // Read path, captured in the setup phase so prdata is a flop
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (sel)
            acat_pkg::ACAT_SEL_RATIO_OVER: rdata_d = limit_word(ratio_over_q);
            acat_pkg::ACAT_SEL_RATIO_UNDER: rdata_d = limit_word(ratio_under_q);
            acat_pkg::ACAT_SEL_ABS_OVER: rdata_d = limit_word(abs_over_q);
            acat_pkg::ACAT_SEL_ABS_UNDER: rdata_d = limit_word(abs_under_q);
            acat_pkg::ACAT_SEL_REF_SELECT: rdata_d[NUM_CH-1:0] = ref_select_q;
            acat_pkg::ACAT_SEL_ALERT_STATUS: begin
                rdata_d[acat_pkg::ALERT_OVER_BIT] = aux_over_alert;
                rdata_d[acat_pkg::ALERT_UNDER_BIT] = aux_under_alert;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            rdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            err_q <= (sel == acat_pkg::ACAT_SEL_NONE);
        end
    end

    // ------------------------------------------------------------------
    // Comparison against the selected limit pair
    // ------------------------------------------------------------------
    logic ch_ok;
    logic use_abs;
    logic [11:0] over_lim;
    logic [11:0] under_lim;
    logic over_hit;
    logic under_hit;
    logic over_clr;
    logic under_clr;

    assign ch_ok = int'(scan_channel) < NUM_CH;
    assign use_abs = ch_ok && ref_select_q[scan_channel];
    assign over_lim = use_abs ? abs_over_q : ratio_over_q;
    assign under_lim = use_abs ? abs_under_q : ratio_under_q;
    // Strict compares: all ones / zero limits can never trip
    assign over_hit = scan_valid && ch_ok && (scan_result > over_lim);
    assign under_hit = scan_valid && ch_ok && (scan_result < under_lim);
    assign over_clr = wr_en && pstrb[0] && sel == acat_pkg::ACAT_SEL_ALERT_STATUS
        && pwdata[acat_pkg::ALERT_OVER_BIT];
    assign under_clr = wr_en && pstrb[0] && sel == acat_pkg::ACAT_SEL_ALERT_STATUS
        && pwdata[acat_pkg::ALERT_UNDER_BIT];

    // ------------------------------------------------------------------
    // Alert flags, sticky until written one; a new hit beats the clear
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_over_alert <= 1'b0;
        end else if (over_hit) begin
            aux_over_alert <= 1'b1;
        end else if (over_clr) begin
            aux_over_alert <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_under_alert <= 1'b0;
        end else if (under_hit) begin
            aux_under_alert <= 1'b1;
        end else if (under_clr) begin
            aux_under_alert <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_ratio_scan;
        scan_valid && ch_ok && !ref_select_q[scan_channel];
    endsequence

    sequence s_abs_scan;
        scan_valid && ch_ok && ref_select_q[scan_channel];
    endsequence

    property p_ratio_over;
        s_ratio_scan and (scan_result > ratio_over_q) |=> aux_over_alert;
    endproperty
    a_ratio_over: assert property (p_ratio_over) else $error("ratio over missed");

    property p_ratio_under;
        s_ratio_scan and (scan_result < ratio_under_q) |=> aux_under_alert;
    endproperty
    a_ratio_under: assert property (p_ratio_under) else $error("ratio under missed");

    property p_abs_over;
        s_abs_scan and (scan_result > abs_over_q) |=> aux_over_alert;
    endproperty
    a_abs_over: assert property (p_abs_over) else $error("abs over missed");

    property p_abs_under;
        s_abs_scan and (scan_result < abs_under_q) |=> aux_under_alert;
    endproperty
    a_abs_under: assert property (p_abs_under) else $error("abs under missed");

    property p_select_abs;
        s_abs_scan and (scan_result > ratio_over_q) and (scan_result <= abs_over_q)
            and (scan_result >= abs_under_q) and !aux_over_alert and !over_clr
            |=> !aux_over_alert;
    endproperty
    a_select_abs: assert property (p_select_abs) else $error("wrong limit set");

    property p_over_off;
        scan_valid && over_lim == acat_pkg::OVER_RESET && !aux_over_alert
            |=> !aux_over_alert;
    endproperty
    a_over_off: assert property (p_over_off) else $error("disabled over fired");

    property p_under_off;
        scan_valid && under_lim == acat_pkg::UNDER_RESET && !aux_under_alert
            |=> !aux_under_alert;
    endproperty
    a_under_off: assert property (p_under_off) else $error("disabled under fired");

    sequence s_lim_read;
        setup && !pwrite && (sel == acat_pkg::ACAT_SEL_RATIO_OVER
            || sel == acat_pkg::ACAT_SEL_ABS_UNDER);
    endsequence

    property p_low_nibble;
        s_lim_read |=> prdata[3:0] == 4'h0 && pready && !pslverr;
    endproperty
    a_low_nibble: assert property (p_low_nibble) else $error("low bits not zero");

    property p_readback;
        wr_en && lo_strobes && sel == acat_pkg::ACAT_SEL_RATIO_UNDER
            |=> ##1 ratio_under_q == $past(wr_limit, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("limit not stored");

    property p_set_wins;
        over_hit && over_clr |=> aux_over_alert [*2] or (aux_over_alert ##1 1'b1);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat set");

    // Partial lane writes must leave a limit untouched
    property p_partial_kept;
        wr_en && !lo_strobes && sel == acat_pkg::ACAT_SEL_RATIO_OVER
            |=> $stable(ratio_over_q);
    endproperty
    a_partial_kept: assert property (p_partial_kept) else $error("partial write landed");

    property p_abs_store;
        wr_en && lo_strobes && sel == acat_pkg::ACAT_SEL_ABS_OVER
            |=> abs_over_q == $past(wr_limit);
    endproperty
    a_abs_store: assert property (p_abs_store) else $error("abs limit not stored");

    property p_high_zero;
        s_lim_read |=> prdata[31:16] == 16'h0000;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high bits not zero");

    property p_ref_store;
        wr_en && pstrb[0] && sel == acat_pkg::ACAT_SEL_REF_SELECT
            |=> ref_select_q == $past(wr_ref);
    endproperty
    a_ref_store: assert property (p_ref_store) else $error("ref select not stored");

    // Channels past the last input are ignored
    property p_idle_channel;
        scan_valid && !ch_ok && !aux_over_alert && !aux_under_alert
            |=> !aux_over_alert && !aux_under_alert;
    endproperty
    a_idle_channel: assert property (p_idle_channel) else $error("ignored channel alerted");

    property p_over_clear;
        over_clr && !over_hit |=> !aux_over_alert;
    endproperty
    a_over_clear: assert property (p_over_clear) else $error("over flag not cleared");

    property p_under_clear;
        under_clr && !under_hit |=> !aux_under_alert;
    endproperty
    a_under_clear: assert property (p_under_clear) else $error("under flag not cleared");

    property p_over_sticky;
        aux_over_alert && !over_clr |=> aux_over_alert;
    endproperty
    a_over_sticky: assert property (p_over_sticky) else $error("over flag dropped");

endmodule

//--- sim/acat_thresholds_test.sv
`timescale 1ns/100ps
module acat_thresholds_test;
    localparam logic [9:0] B = {2'b00, acat_pkg::IDX_RATIO_OVER};
    localparam logic [9:0] RS = {2'b00, acat_pkg::IDX_REF_SELECT};
    localparam logic [9:0] ST = {2'b00, acat_pkg::IDX_ALERT_STATUS};
    logic pclk, presetn, psel, penable, pwrite, scan_valid, pready, pslverr;
    logic aux_over_alert, aux_under_alert, ov, uv;
    logic pend = 1'b0;
    logic [11:0] paddr, scan_result;
    logic [31:0] pwdata, prdata, rn;
    logic [3:0] pstrb;
    logic [2:0] scan_channel;
    logic [33:0] bq[$];
    logic [1:0] aq[$];
    logic [11:0] lim[4];
    logic [5:0] rsel;
    logic [33:0] e;
    logic [1:0] a;
    int failures = 0, num_checks = 0, cyc = 0, seed = 34, i, c;

    acat_thresholds i_acat_thresholds (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scan_valid(scan_valid),
        .scan_channel(scan_channel), .scan_result(scan_result),
        .aux_over_alert(aux_over_alert), .aux_under_alert(aux_under_alert));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task test_done;
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            failures++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask

    // ------------------------------------------------------------------
    // Drivers, each noting what the monitor must see
    // ------------------------------------------------------------------
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
             input logic [3:0] s, input logic err, input logic [31:0] rx);
        bq.push_back({~w, err, rx});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        pstrb <= s;
        scan_valid <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic mapped(input logic [9:0] idx);
        return (idx >= B && idx <= B + 10'h3) || idx == RS || idx == ST;
    endfunction

    task wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 4'hf, ~mapped(idx), 32'h0);
        if (idx >= B && idx <= B + 10'h3) lim[idx - B] = d[15:4];
        if (idx == RS) rsel = d[5:0];
        if (idx == ST) begin
            ov = ov & ~d[0];
            uv = uv & ~d[1];
        end
    endtask

    task rd(input logic [9:0] idx);
        logic [31:0] x;
        x = 32'h0;
        if (idx >= B && idx <= B + 10'h3) x = {16'h0, lim[idx - B], 4'h0};
        if (idx == RS) x = {26'h0, rsel};
        if (idx == ST) x = {30'h0, uv, ov};
        apb(1'b0, idx, 32'h0, 4'h0, ~mapped(idx), x);
    endtask

    function automatic logic [11:0] lv(input int ch, input int k);
        return rsel[ch] ? lim[2 + k] : lim[k];
    endfunction

    // Keeps each under limit at or below its over limit
    function automatic logic [11:0] keep(input int k, input logic [11:0] v);
        if (k % 2 == 0 && v < lim[k + 1]) return lim[k + 1];
        if (k % 2 == 1 && v > lim[k - 1]) return lim[k - 1];
        return v;
    endfunction

    task scan(input logic [2:0] ch, input logic [11:0] r);
        @(posedge pclk);
        scan_valid <= 1'b1;
        scan_channel <= ch;
        scan_result <= r;
        if (ch < 3'h6) begin
            ov = ov | (r > lv(ch, 0));
            uv = uv | (r < lv(ch, 1));
        end
        aq.push_back({uv, ov});
    endtask

    // ------------------------------------------------------------------
    // Monitor: alerts are due one cycle after the scan is taken
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        if (presetn && psel && penable) begin
            chk("pready", 32'h1, {31'h0, pready});
            if (pready) begin
                e = bq.pop_front();
                chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
                if (e[33]) chk("prdata", e[31:0], prdata);
            end
        end
        if (pend) begin
            a = aq.pop_front();
            chk("alerts", {30'h0, a}, {30'h0, aux_under_alert, aux_over_alert});
        end
        pend <= scan_valid & presetn;
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            failures++;
            test_done;
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, scan_valid, ov, uv} = 7'h00;
        {paddr, pwdata, pstrb, scan_channel, scan_result, rsel} = '0;
        lim = '{12'hfff, 12'h000, 12'hfff, 12'h000};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) rd(B + i[9:0]);
        rd(RS);
        rd(ST);
        for (i = 0; i < 4; i++) begin
            rn = $random(seed);
            wr(B + i[9:0], {rn[31:16], keep(i, rn[15:4]), rn[3:0]});
            rd(B + i[9:0]);
        end
        wr(10'h3e, 32'h0000_1230);
        rd(10'h3e);
        rd(10'h3ff);
        apb(1'b1, B, 32'h0000_5670, 4'h1, 1'b0, 32'h0);
        rd(B);
        wr(B, 32'h8000);
        wr(B + 10'h1, 32'h4000);
        wr(B + 10'h2, 32'ha000);
        wr(B + 10'h3, 32'h2000);
        for (i = 0; i < 4; i++) begin
            wr(RS, (i == 0) ? 32'h0 : (i == 1) ? 32'h3f : (i == 2) ? 32'h15 : 32'h2a);
            for (c = 0; c < 6; c++) begin
                scan(c[2:0], lv(c, 0));
                scan(c[2:0], lv(c, 1));
                scan(c[2:0], lv(c, 0) + 12'h1);
                rd(ST);
                wr(ST, 32'h3);
                scan(c[2:0], lv(c, 1) - 12'h1);
                wr(ST, 32'h3);
            end
        end
        // Clear and a fresh over hit on one edge: the hit wins
        fork
            wr(ST, 32'h3);
            begin
                @(posedge pclk);
                scan(3'h0, 12'hfff);
                @(posedge pclk);
                scan_valid <= 1'b0;
            end
        join
        ov = 1'b1;
        rd(ST);
        wr(ST, 32'h3);
        wr(B, 32'hfff0);
        wr(B + 10'h1, 32'h0);
        wr(B + 10'h2, 32'hfff0);
        wr(B + 10'h3, 32'h0);
        for (i = 0; i < 12; i++) begin
            wr(RS, (i < 6) ? 32'h0 : 32'h3f);
            scan(3'(i % 6), 12'hfff);
            scan(3'(i % 6), 12'h000);
        end
        for (i = 0; i < 300; i++) begin
            rn = $random(seed);
            if (i % 25 == 0) begin
                wr(B + rn[9:8], {rn[31:16], keep(rn[9:8], rn[15:4]), rn[3:0]});
            end
            if (i % 10 == 0) wr(RS, rn);
            scan(rn[30:28], rn[27:16]);
            if (i % 9 == 0) wr(ST, {30'h0, rn[5:4]});
        end
        rd(ST);
        repeat (2) @(posedge pclk);
        test_done;
    end
endmodule
